/* File: verilog/self_test_pkg.sv */
// constants, types and log entry layout for the drive self-test sequencer
package self_test_pkg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  localparam int FC_MSB = 7;
  localparam int FC_LSB = 5;
  localparam logic [2:0] FC_SHORT = 3'h1;
  localparam logic [2:0] FC_EXTENDED = 3'h2;
  localparam logic [2:0] FC_ABORT = 3'h4;

  // ----------------------------------------------------------------
  // result field codes
  // ----------------------------------------------------------------
  localparam logic [3:0] RES_PASS = 4'h0;
  localparam logic [3:0] RES_ABORT_CMD = 4'h1;
  localparam logic [3:0] RES_ABORT_RESET = 4'h2;
  localparam logic [3:0] RES_FAIL_ELEC = 4'h5;
  localparam logic [3:0] RES_FAIL_SERVO = 4'h6;
  localparam logic [3:0] RES_FAIL_READ = 4'h7;
  localparam logic [3:0] RES_IN_PROGRESS = 4'hf;

  // ----------------------------------------------------------------
  // log and not-ready sense
  // ----------------------------------------------------------------
  localparam int LOG_DEPTH = 20;
  localparam logic [4:0] LOG_FULL = 5'd20;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_NOT_READY = 4'h2;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_NOT_READY = 8'h04;
  localparam logic [7:0] ASCQ_CAUSE_UNKNOWN = 8'h00;
  localparam logic [7:0] ASCQ_MANUAL = 8'h03;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 10_000_000;
  localparam longint SHORT_LIMIT_S = 120;
  localparam logic [31:0] SHORT_LIMIT_CYCLES = 32'(SHORT_LIMIT_S * CLK_HZ);
  localparam logic [15:0] EXT_DURATION_DEFAULT = 16'h003c;

  typedef enum logic [1:0] {SEG_ELECTRICAL = 2'b00, SEG_SERVO = 2'b01, SEG_READ_SCAN = 2'b10} segment_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_OPEN = 2'b01, ST_RUN = 2'b10, ST_CLOSE = 2'b11} seq_state_t;

  typedef struct packed {
    logic [2:0] func;
    logic [3:0] result;
    logic [3:0] sense_key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] fru;
    logic lba_valid;
    logic [31:0] lba;
  } log_entry_t;

endpackage

/* File: verilog/drive_self_test.sv */
// drive self-test sequencer: command decode, segment sequencing, results log
//
// Operation
// - byte 1 bits 7:5 select the test
// - motor, servo, config faults answer 02/04/00 or 02/04/03
// - each test runs electrical, servo, read/verify segments
// - short test stops at 120 s, partial scan
// - extended test scans every block, full exercise
// - extended test duration exposed to host
// - retries stay on, channel/servo parameters untouched
// - only unrecovered errors after retries are failures
// - new entry inserted at head, older ones shift
// - log holds twenty entries, oldest dropped
// - new entry copies code, result Fh, then stored
// - completion or abort rewrites result in storage
// - four-bit result, zero pass, nonzero failure reason
// - failure records sense key, ASC, ASCQ, FRU, LBA
// - abort function code sets result 01
// - bus or device reset aborts with result 02
`timescale 1ns/10ps
module drive_self_test
  import self_test_pkg::*;
#(
  parameter logic [31:0] SHORT_LIMIT = SHORT_LIMIT_CYCLES,
  parameter logic [15:0] EXT_DURATION = EXT_DURATION_DEFAULT
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic diag_cmd_valid,
  input wire logic [7:0] diag_byte1,
  output logic diag_accept,
  output logic diag_reject,
  input wire logic bus_reset,
  input wire logic device_reset,
  input wire logic motor_fault,
  input wire logic servo_lock_fault,
  input wire logic config_unreadable,
  input wire logic tur_req,
  output logic tur_done,
  output logic [3:0] tur_sense_key,
  output logic [7:0] tur_asc,
  output logic [7:0] tur_ascq,
  output logic seg_start,
  output logic [1:0] seg_sel,
  output logic seg_full_scan,
  output logic seg_abort,
  output logic retry_enable,
  output logic params_locked,
  input wire logic seg_done,
  input wire logic seg_unrecovered,
  input wire logic [3:0] fail_sense_key,
  input wire logic [7:0] fail_asc,
  input wire logic [7:0] fail_ascq,
  input wire logic [7:0] fail_fru,
  input wire logic fail_lba_valid,
  input wire logic [31:0] fail_lba,
  output logic nv_store_req,
  input wire logic nv_store_done,
  input wire logic [4:0] log_rd_index,
  output log_entry_t log_rd_entry,
  output logic [4:0] log_count,
  output logic test_busy,
  output logic [15:0] ext_duration
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  segment_t seg;
  log_entry_t log_mem [0:LOG_DEPTH-1];
  logic [31:0] run_timer;
  logic short_mode;
  logic abort_pending;

  wire [2:0] fc = diag_byte1[FC_MSB:FC_LSB];
  wire fc_test = (fc == FC_SHORT) || (fc == FC_EXTENDED);
  wire not_ready = motor_fault || servo_lock_fault || config_unreadable;
  wire start = diag_cmd_valid && fc_test && (state == ST_IDLE) && !not_ready;
  wire busy_req = diag_cmd_valid && fc_test && (state != ST_IDLE);
  wire abort_req = diag_cmd_valid && (fc == FC_ABORT) && (state != ST_IDLE);
  wire any_reset = bus_reset || device_reset;
  // an abort during the closing store is too late to matter; the result is already final
  wire can_abort = (state == ST_OPEN) || (state == ST_RUN);
  wire do_abort = can_abort && (abort_req || any_reset);
  // reset-caused abort wins when both arrive together
  wire [3:0] abort_code = any_reset ? RES_ABORT_RESET : RES_ABORT_CMD;
  wire timed_out = (state == ST_RUN) && short_mode && (run_timer >= SHORT_LIMIT - 32'd1);
  wire seg_fail = (state == ST_RUN) && seg_done && seg_unrecovered;
  wire seg_ok = (state == ST_RUN) && seg_done && !seg_unrecovered;
  wire last_seg = (seg == SEG_READ_SCAN);
  wire finish_pass = (seg_ok && last_seg) || timed_out;

  wire [3:0] fail_code = (seg == SEG_ELECTRICAL) ? RES_FAIL_ELEC :
    (seg == SEG_SERVO) ? RES_FAIL_SERVO : RES_FAIL_READ;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start)
          next_state = ST_OPEN;
      ST_OPEN:
        if (nv_store_done)
          next_state = (abort_pending || do_abort) ? ST_CLOSE : ST_RUN;
      ST_RUN:
        if (do_abort || seg_fail || finish_pass)
          next_state = ST_CLOSE;
      ST_CLOSE:
        if (nv_store_done)
          next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      abort_pending <= 1'b0;
    else if (state == ST_OPEN && do_abort)
      abort_pending <= 1'b1;
    else if (state != ST_OPEN)
      abort_pending <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      short_mode <= 1'b0;
    else if (start)
      short_mode <= (fc == FC_SHORT);
  end

  // timer only matters for the short test; extended runs as long as the scan needs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      run_timer <= 32'h0000_0000;
    else if (state != ST_RUN)
      run_timer <= 32'h0000_0000;
    else
      run_timer <= run_timer + 32'd1;
  end

  // ----------------------------------------------------------------
  // segment control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seg <= SEG_ELECTRICAL;
      seg_start <= 1'b0;
      seg_abort <= 1'b0;
    end
    else
    begin
      seg_start <= 1'b0;
      seg_abort <= 1'b0;
      if (start)
        seg <= SEG_ELECTRICAL;
      if (state == ST_OPEN && nv_store_done && !abort_pending && !do_abort)
        seg_start <= 1'b1;
      if (seg_ok && !last_seg && !do_abort && !timed_out)
      begin
        seg <= segment_t'(seg + 2'd1);
        seg_start <= 1'b1;
      end
      if (state == ST_RUN && (do_abort || timed_out))
        seg_abort <= 1'b1;
    end
  end

  assign seg_sel = seg;
  assign seg_full_scan = !short_mode;
  assign retry_enable = 1'b1;
  assign params_locked = 1'b1;
  assign nv_store_req = (state == ST_OPEN) || (state == ST_CLOSE);
  assign test_busy = (state != ST_IDLE);

  // ----------------------------------------------------------------
  // results log
  // ----------------------------------------------------------------
  log_entry_t new_entry;
  log_entry_t next_head;
  always_comb
  begin
    new_entry = '0;
    new_entry.func = fc;
    new_entry.result = RES_IN_PROGRESS;
    next_head = log_mem[0];
    if (start)
      next_head = new_entry;
    else if (do_abort)
      next_head.result = abort_code;
    else if (seg_fail)
    begin
      next_head.result = fail_code;
      next_head.sense_key = fail_sense_key;
      next_head.asc = fail_asc;
      next_head.ascq = fail_ascq;
      next_head.fru = fail_fru;
      next_head.lba_valid = fail_lba_valid;
      next_head.lba = fail_lba;
    end
    else if (finish_pass)
      next_head.result = RES_PASS;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      log_mem[0] <= '0;
    else
      log_mem[0] <= next_head;
  end

  // the oldest entry simply falls off the end of the shift
  genvar gi;
  generate
    for (gi = 1; gi < LOG_DEPTH; gi++)
    begin : g_shift
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          log_mem[gi] <= '0;
        else if (start)
          log_mem[gi] <= log_mem[gi-1];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      log_count <= 5'd0;
    else if (start && log_count != LOG_FULL)
      log_count <= log_count + 5'd1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      log_rd_entry <= '0;
    else if (log_rd_index < LOG_FULL)
      log_rd_entry <= log_mem[log_rd_index];
    else
      log_rd_entry <= '0;
  end

  // ----------------------------------------------------------------
  // host answers
  // ----------------------------------------------------------------
  // busy is also not-ready, with the same 02/04/00 sense as a motor or servo fault
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      diag_accept <= 1'b0;
      diag_reject <= 1'b0;
      tur_done <= 1'b0;
      tur_sense_key <= SK_NONE;
      tur_asc <= ASC_NONE;
      tur_ascq <= ASCQ_CAUSE_UNKNOWN;
      ext_duration <= 16'h0000;
    end
    else
    begin
      diag_accept <= start || abort_req;
      diag_reject <= busy_req || (diag_cmd_valid && fc_test && not_ready);
      tur_done <= tur_req;
      ext_duration <= EXT_DURATION;
      if (tur_req)
      begin
        tur_sense_key <= (not_ready || test_busy) ? SK_NOT_READY : SK_NONE;
        tur_asc <= (not_ready || test_busy) ? ASC_NOT_READY : ASC_NONE;
        tur_ascq <= config_unreadable ? ASCQ_MANUAL : ASCQ_CAUSE_UNKNOWN;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_tur_not_ready: assert property (@(posedge clk) disable iff (!reset_n)
    tur_req && motor_fault |=> tur_done && tur_sense_key == 4'h2 && tur_asc == 8'h04)
    else $error("not-ready sense missing");
  a_seg_order: assert property (@(posedge clk) disable iff (!reset_n)
    seg_ok && seg == SEG_ELECTRICAL && !do_abort && !timed_out |=> seg_start && seg_sel == 2'b01)
    else $error("servo segment did not follow electrical");
  a_short_bound: assert property (@(posedge clk) disable iff (!reset_n)
    state == ST_RUN && short_mode |-> run_timer < SHORT_LIMIT)
    else $error("short test overran its limit");
  a_ext_full_scan: assert property (@(posedge clk) disable iff (!reset_n)
    state == ST_RUN |-> seg_full_scan == (log_mem[0].func == FC_EXTENDED))
    else $error("scan width does not match requested test");
  a_recovered_ok: assert property (@(posedge clk) disable iff (!reset_n)
    seg_ok && !last_seg && !do_abort && !timed_out |=> state == ST_RUN && log_mem[0].result == 4'hf)
    else $error("recovered segment ended the test");
  a_head_insert: assert property (@(posedge clk) disable iff (!reset_n)
    start |=> log_mem[1] == $past(log_mem[0]) && log_mem[0].result == 4'hf && nv_store_req)
    else $error("new entry not inserted at head");
  a_log_cap: assert property (@(posedge clk) disable iff (!reset_n)
    log_count <= 5'd20)
    else $error("log count beyond twenty");
  a_abort_cmd: assert property (@(posedge clk) disable iff (!reset_n)
    state == ST_RUN && abort_req && !any_reset |=> log_mem[0].result == 4'h1 && state == ST_CLOSE && seg_abort)
    else $error("abort code not recorded");
  a_reset_abort: assert property (@(posedge clk) disable iff (!reset_n)
    state == ST_RUN && any_reset |=> log_mem[0].result == 4'h2 && state == ST_CLOSE && seg_abort)
    else $error("reset did not abort test");
  a_busy_reject: assert property (@(posedge clk) disable iff (!reset_n)
    busy_req |=> diag_reject && !diag_accept && $stable(log_count))
    else $error("second request accepted while busy");

endmodule

/* File: verification/media_stub.sv */
// far-side stub: segment engine and non-volatile store responder
`timescale 1ns/10ps
module media_stub
#(
  parameter logic [60:0] FAIL_VAL = '0
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic seg_start,
  input wire logic [1:0] seg_sel,
  input wire logic seg_abort,
  input wire logic nv_store_req,
  input wire logic [9:0] seg_delay,
  input wire logic [1:0] fail_seg,
  output logic seg_done,
  output logic seg_unrecovered,
  output logic [60:0] fail_info,
  output logic nv_store_done
);
  logic [9:0] cnt;
  logic run;
  logic [1:0] nv_cnt;
  logic [1:0] sel;
  // other segments recover after retries and stay silent
  assign seg_unrecovered = seg_done && (sel == fail_seg);
  // fields mean nothing outside a failing done, so they keep moving
  assign fail_info = seg_unrecovered ? FAIL_VAL : ~FAIL_VAL ^ {61{cnt[0]}};
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run <= 1'b0;
      cnt <= '0;
      sel <= '0;
      seg_done <= 1'b0;
      nv_cnt <= '0;
      nv_store_done <= 1'b0;
    end
    else
    begin
      seg_done <= 1'b0;
      nv_store_done <= 1'b0;
      if (seg_start)
      begin
        run <= 1'b1;
        cnt <= seg_delay;
        sel <= seg_sel;
      end
      else if (seg_abort)
        run <= 1'b0;
      else if (run && cnt == 10'h000)
      begin
        run <= 1'b0;
        seg_done <= 1'b1;
      end
      else if (run)
        cnt <= cnt - 10'h001;
      // slow store, answered only while asked
      nv_cnt <= (nv_store_req && !nv_store_done) ? nv_cnt + 2'h1 : 2'h0;
      if (nv_store_req && nv_cnt == 2'h3)
        nv_store_done <= 1'b1;
    end
  end
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the drive self-test sequencer
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module testbench;
  import self_test_pkg::*;
  localparam logic [60:0] FI = {4'h3, 8'h11, 8'h01, 8'h05, 1'b1, 32'h0000_1234};
  typedef struct packed {logic [2:0] code; logic [9:0] dly; logic [1:0] fseg; logic [3:0] res; logic [5:0] hist; logic ab;} row_t;
  logic clk = 1'b0, reset_n = 1'b0, cmd_v = 1'b0, bus_reset = 1'b0, device_reset = 1'b0, tur_req = 1'b0;
  logic [7:0] byte1 = 8'h00;
  logic [2:0] faults = 3'h0;
  logic [4:0] rd_idx = 5'h00;
  logic [9:0] dly = 10'h001;
  logic [1:0] fseg = 2'h3;
  logic acc, rej, tdone, sstart, full, sabort, ren, plock, sdone, sunrec, nvreq, nvdone, busy, fs, ab;
  logic [1:0] ssel;
  logic [3:0] sk;
  logic [7:0] asc, ascq;
  logic [60:0] fi;
  logic [4:0] cnt;
  logic [15:0] edur;
  logic [5:0] hist;
  log_entry_t ent;
  row_t r;
  int nvn, i, k;
  int err_total = 0, tests_run = 0;
  // row 2: the time limit cuts the short test inside its servo segment
  row_t rows [0:5] = '{'{3'h1, 10'd5, 2'h3, 4'h0, 6'h06, 1'b0},
                       '{3'h2, 10'd150, 2'h3, 4'h0, 6'h06, 1'b0},
                       '{3'h1, 10'd150, 2'h3, 4'h0, 6'h01, 1'b1},
                       '{3'h1, 10'd5, 2'h0, 4'h5, 6'h00, 1'b0},
                       '{3'h2, 10'd5, 2'h1, 4'h6, 6'h01, 1'b0},
                       '{3'h2, 10'd5, 2'h2, 4'h7, 6'h06, 1'b0}};
  always #50 clk = ~clk;
  drive_self_test #(.SHORT_LIMIT(32'd200), .EXT_DURATION(16'h0123)) uut (.clk(clk), .reset_n(reset_n),
    .diag_cmd_valid(cmd_v), .diag_byte1(byte1), .diag_accept(acc), .diag_reject(rej), .bus_reset(bus_reset),
    .device_reset(device_reset), .motor_fault(faults[2]), .servo_lock_fault(faults[1]),
    .config_unreadable(faults[0]), .tur_req(tur_req), .tur_done(tdone), .tur_sense_key(sk), .tur_asc(asc),
    .tur_ascq(ascq), .seg_start(sstart), .seg_sel(ssel), .seg_full_scan(full), .seg_abort(sabort),
    .retry_enable(ren), .params_locked(plock), .seg_done(sdone), .seg_unrecovered(sunrec),
    .fail_sense_key(fi[60:57]), .fail_asc(fi[56:49]), .fail_ascq(fi[48:41]), .fail_fru(fi[40:33]),
    .fail_lba_valid(fi[32]), .fail_lba(fi[31:0]), .nv_store_req(nvreq), .nv_store_done(nvdone),
    .log_rd_index(rd_idx), .log_rd_entry(ent), .log_count(cnt), .test_busy(busy), .ext_duration(edur));
  media_stub #(.FAIL_VAL(FI)) stub (.clk(clk), .reset_n(reset_n), .seg_start(sstart), .seg_sel(ssel),
    .seg_abort(sabort), .nv_store_req(nvreq), .seg_delay(dly), .fail_seg(fseg), .seg_done(sdone),
    .seg_unrecovered(sunrec), .fail_info(fi), .nv_store_done(nvdone));
  // --------------------------------------------------------------
  // monitors and tasks
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    if (sstart === 1'b1)
    begin
      hist <= {hist[3:0], ssel};
      fs <= full;
    end
    if (sabort === 1'b1)
      ab <= 1'b1;
    if (nvdone === 1'b1)
      nvn <= nvn + 1;
  end
  task automatic cmd(input logic [2:0] code);
    @(negedge clk);
    cmd_v = 1'b1;
    byte1 = {code, 5'h00};
    @(negedge clk);
    cmd_v = 1'b0;
  endtask
  task automatic go(input logic [2:0] code);
    hist = 6'h00;
    ab = 1'b0;
    nvn = 0;
    cmd(code);
  endtask
  task automatic tur;
    @(negedge clk);
    tur_req = 1'b1;
    @(negedge clk);
    tur_req = 1'b0;
  endtask
  task automatic rd(input logic [4:0] idx);
    @(negedge clk);
    rd_idx = idx;
    @(negedge clk);
  endtask
  task automatic wait_idle;
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
      @(negedge clk);
    `CHK(busy, 1'b0)
    rd(5'h00);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    err_total++;
    wrap_up;
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge clk);
    `CHK({cnt, busy, ren, plock}, 8'h03)
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(edur, 16'h0123)
    for (i = 0; i < 6; i++)
    begin
      r = rows[i];
      dly = r.dly;
      fseg = r.fseg;
      tur;
      `CHK({tdone, sk}, 5'h10)
      go(r.code);
      `CHK({acc, rej}, 2'b10)
      rd(5'h00);
      `CHK({ent.func, ent.result}, {r.code, RES_IN_PROGRESS})
      wait_idle;
      `CHK({ent.func, ent.result, ab}, {r.code, r.res, r.ab})
      `CHK({nvn, fs, ren, plock}, {32'd2, r.code == FC_EXTENDED, 2'b11})
      `CHK(hist, r.hist)
      if (r.res != RES_PASS)
        `CHK(ent[60:0], FI)
    end
    for (i = 0; i < 3; i++)
    begin
      faults = 3'h4 >> i;
      tur;
      `CHK({sk, asc, ascq}, {SK_NOT_READY, ASC_NOT_READY, i == 2 ? ASCQ_MANUAL : ASCQ_CAUSE_UNKNOWN})
      cmd(FC_SHORT);
      `CHK({acc, rej, busy, cnt}, {3'b010, 5'd6})
    end
    faults = 3'h0;
    // second request and an idle abort must both leave the log alone
    dly = 10'd100;
    fseg = 2'h3;
    go(FC_SHORT);
    cmd(FC_EXTENDED);
    `CHK({acc, rej, cnt}, {2'b01, 5'd7})
    tur;
    `CHK({sk, asc, ascq}, {SK_NOT_READY, ASC_NOT_READY, ASCQ_CAUSE_UNKNOWN})
    repeat (10) @(negedge clk);
    cmd(FC_ABORT);
    `CHK(acc, 1'b1)
    wait_idle;
    `CHK({ent.result, cnt, ab}, {RES_ABORT_CMD, 5'd7, 1'b1})
    cmd(FC_ABORT);
    `CHK({acc, rej}, 2'b00)
    for (i = 0; i < 2; i++)
    begin
      go(FC_EXTENDED);
      repeat (10) @(negedge clk);
      {bus_reset, device_reset} = 2'b10 >> i;
      @(negedge clk);
      {bus_reset, device_reset} = 2'b00;
      wait_idle;
      `CHK(ent.result, RES_ABORT_RESET)
    end
    // abort while the opening store is pending: no segment may start
    go(FC_SHORT);
    cmd(FC_ABORT);
    wait_idle;
    `CHK({ent.result, nvn, hist, ab}, {RES_ABORT_CMD, 32'd2, 6'h00, 1'b0})
    dly = 10'd1;
    for (i = 0; i < 30 && cnt !== LOG_FULL; i++)
    begin
      go(FC_SHORT);
      wait_idle;
    end
    go(FC_EXTENDED);
    wait_idle;
    `CHK({ent.func, cnt}, {FC_EXTENDED, LOG_FULL})
    rd(5'h01);
    `CHK({ent.func, ent.result}, {FC_SHORT, RES_PASS})
    rd(5'd19);
    `CHK({ent.func, ent.result}, {FC_EXTENDED, RES_PASS})
    rd(5'd20);
    `CHK(ent, 68'h0)
    wrap_up;
  end
endmodule
